// [rtl/pbs_scheduler.sv]
`timescale 1ns/1ps
`include "pbs_params.svh"

// How it works
// - sync: warm-up at frames*80ms plus skipped*1874.375ms plus off time minus 167.5ms
// - sync: tasks disabled at frames*80ms plus skipped*1874.375ms minus 247.5ms
// - async: warm-up at (frames minus two)*80ms plus off time
// - async: tasks disabled at (frames minus three)*80ms
// - report holds current and next frame; skipped is gap minus one
// - warm-up start is the single step out of the off state
// - shutdown for a running task starts before the disable point
// - task time counts from the accepted request write
// - noise detect ends after total warm-up plus 82ms
// - failed search ends after total warm-up plus search time plus 47ms
// - chained noise and search end after warm-up plus search time plus 127ms
// - async noise detect finding signal chains a search unless disabled
// - total warm-up is enabled step times plus sync setting time
module pbs_scheduler
  import pbs_pkg::*;
#(
  parameter int TICK_CYC = `PBS_TICK_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // receiver side
  input wire logic paging_signal_found,
  output logic rx_warmup_start,
  output logic rx_shutdown_start,
  output logic tasks_disabled
);

  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt, rdata_r, rdata_nxt, wval;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic do_wr, wr_ctrl, wr_rpt;

  pbs_cfg_s cfg_r, cfg_nxt;
  pbs_report_s rpt_r, rpt_nxt;
  pbs_task_e task_r, task_nxt;
  logic [13:0] div_r, div_nxt;
  logic tick_r, tick_nxt, recalc_r, recalc_nxt, sched_on_r, sched_on_nxt;
  logic warm_done_r, warm_done_nxt, tasks_dis_r, tasks_dis_nxt;
  logic rx_warm_r, rx_warm_nxt, rx_shut_r, rx_shut_nxt;
  logic refused_r, refused_nxt, cut_r, cut_nxt, near_dis, chain_ok;
  logic [23:0] elapsed_r, elapsed_nxt, warm_pt_r, warm_pt_nxt;
  logic [23:0] dis_pt_r, dis_pt_nxt, task_el_r, task_el_nxt;
  logic [23:0] task_end_r, task_end_nxt;
  logic [23:0] tf, sk, wbase, wadj, dbase, dadj;
  logic [6:0] skip;
  logic [17:0] warm_total;

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      `PBS_A_CTRL: v = {30'h0, cfg_r.auto_search_disable, cfg_r.sync};
      `PBS_A_REPORT: v = {8'h0, rpt_r.time_to_next_frame, 1'b0, rpt_r.next_needed_frame, 1'b0, rpt_r.cf};
      `PBS_A_RXOFF: v = {16'h0, cfg_r.rx_off};
      `PBS_A_STEPS: v = cfg_r.steps;
      `PBS_A_WCFG: v = {8'h0, cfg_r.sync_set, 4'h0, cfg_r.step_en};
      `PBS_A_AST: v = {16'h0, cfg_r.ast};
      `PBS_A_STAT: v = {17'h0, skip, 2'h0, cut_r, refused_r,
                        task_r != TASK_IDLE, tasks_dis_r, warm_done_r,
                        sched_on_r};
      `PBS_A_WPT: v = {8'h0, warm_pt_r};
      `PBS_A_DPT: v = {8'h0, dis_pt_r};
      default: v = 32'h0;
    endcase
    return v;
  endfunction : rd_word

  // byte lanes not strobed keep their stored value
  always_comb begin
    wval = rd_word(aw_addr_r);
    for (int i = 0; i < 4; i++) begin
      if (w_strb_r[i]) begin
        wval[i*8 +: 8] = w_data_r[i*8 +: 8];
      end
    end
  end

  assign do_wr = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_ctrl = do_wr && aw_addr_r == `PBS_A_CTRL;
  assign wr_rpt = do_wr && aw_addr_r == `PBS_A_REPORT;

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt = w_hold_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (awvalid && awready_r) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = awaddr;
    end
    if (wvalid && wready_r) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = wdata;
      w_strb_nxt = wstrb;
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (aw_addr_r <= `PBS_A_AST && aw_addr_r[1:0] == 2'h0) ?
                  `PBS_OKAY : `PBS_SLVERR;
    end
    awready_nxt = !aw_hold_nxt && !bvalid_nxt;
    wready_nxt = !w_hold_nxt && !bvalid_nxt;
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_word(araddr);
      rresp_nxt = (araddr <= `PBS_A_DPT && araddr[1:0] == 2'h0) ?
                  `PBS_OKAY : `PBS_SLVERR;
    end
    arready_nxt = !rvalid_nxt;
  end

  assign skip = 7'(rpt_r.next_needed_frame - rpt_r.cf - 7'h1);
  always_comb begin
    warm_total = 18'(cfg_r.sync_set);
    for (int i = 0; i < 4; i++) begin
      if (cfg_r.step_en[i]) begin
        warm_total = warm_total + 18'(cfg_r.steps[i*8 +: 8]);
      end
    end
  end

  always_comb begin
    tf = 24'(rpt_r.time_to_next_frame) * 24'(`PBS_T(`PBS_FRAME_US));
    sk = 24'(skip) * 24'(`PBS_T(`PBS_SKIP_US));
    if (cfg_r.sync) begin
      wbase = tf + sk + 24'(cfg_r.rx_off);
      wadj = 24'(`PBS_T(`PBS_SWARM_US));
      dbase = tf + sk;
      dadj = 24'(`PBS_T(`PBS_SDIS_US));
    end else begin
      wbase = tf + 24'(cfg_r.rx_off);
      wadj = 24'(`PBS_AWARM_N * `PBS_T(`PBS_FRAME_US));
      dbase = tf;
      dadj = 24'(`PBS_ADIS_N * `PBS_T(`PBS_FRAME_US));
    end
  end

  // one tick early, so a cut task is shut down ahead of the disable point
  assign near_dis = sched_on_r && !recalc_r &&
                    (dis_pt_r == 24'h0 || elapsed_r >= dis_pt_r - 24'h1);
  assign chain_ok = !cfg_r.sync && !cfg_r.auto_search_disable && paging_signal_found;

  always_comb begin
    cfg_nxt = cfg_r;
    rpt_nxt = rpt_r;
    recalc_nxt = recalc_r;
    sched_on_nxt = sched_on_r;
    elapsed_nxt = elapsed_r;
    warm_pt_nxt = warm_pt_r;
    dis_pt_nxt = dis_pt_r;
    warm_done_nxt = warm_done_r;
    tasks_dis_nxt = tasks_dis_r;
    task_nxt = task_r;
    task_el_nxt = task_el_r;
    task_end_nxt = task_end_r;
    refused_nxt = refused_r;
    cut_nxt = cut_r;
    rx_warm_nxt = 1'b0;
    rx_shut_nxt = 1'b0;
    tick_nxt = 1'b0;
    div_nxt = div_r + 14'h1;
    if (div_r == 14'(TICK_CYC - 1)) begin
      div_nxt = 14'h0;
      tick_nxt = 1'b1;
    end
    if (wr_ctrl) begin
      cfg_nxt.sync = wval[`PBS_C_SYNC];
      cfg_nxt.auto_search_disable = wval[`PBS_C_DAS];
    end
    if (do_wr && aw_addr_r == `PBS_A_RXOFF) cfg_nxt.rx_off = wval[15:0];
    if (do_wr && aw_addr_r == `PBS_A_STEPS) cfg_nxt.steps = wval;
    if (do_wr && aw_addr_r == `PBS_A_WCFG) begin
      cfg_nxt.step_en = wval[3:0];
      cfg_nxt.sync_set = wval[23:8];
    end
    if (do_wr && aw_addr_r == `PBS_A_AST) cfg_nxt.ast = wval[15:0];
    // a new report restarts the schedule one cycle later
    if (wr_rpt) begin
      rpt_nxt = {wval[23:16], wval[14:8], wval[6:0]};
      recalc_nxt = 1'b1;
    end
    if (recalc_r) begin
      warm_pt_nxt = (wbase > wadj) ? wbase - wadj : 24'h0;
      dis_pt_nxt = (dbase > dadj) ? dbase - dadj : 24'h0;
      elapsed_nxt = 24'h0;
      sched_on_nxt = 1'b1;
      warm_done_nxt = 1'b0;
      tasks_dis_nxt = 1'b0;
      recalc_nxt = wr_rpt;
    end else if (sched_on_r) begin
      if (tick_r && elapsed_r != 24'hFF_FFFF) elapsed_nxt = elapsed_r + 24'h1;
      if (!warm_done_r && elapsed_r >= warm_pt_r) begin
        warm_done_nxt = 1'b1;
        rx_warm_nxt = 1'b1;
      end
      if (elapsed_r >= dis_pt_r) tasks_dis_nxt = 1'b1;
    end
    // clear first so a same-cycle event still sets the flag
    if (wr_ctrl && wval[`PBS_C_CLR]) begin
      refused_nxt = 1'b0;
      cut_nxt = 1'b0;
    end
    unique case (task_r)
      TASK_IDLE: begin
        if (wr_ctrl && (wval[`PBS_C_NREQ] || wval[`PBS_C_SREQ])) begin
          // late requests are refused, not queued
          if (near_dis || tasks_dis_r) begin
            refused_nxt = 1'b1;
          end else if (wval[`PBS_C_NREQ]) begin
            task_nxt = TASK_NOISE;
            task_el_nxt = 24'h0;
            task_end_nxt = 24'(warm_total) + 24'(`PBS_T(`PBS_NOISE_US));
          end else begin
            task_nxt = TASK_SEARCH;
            task_el_nxt = 24'h0;
            task_end_nxt = 24'(warm_total) + 24'(cfg_r.ast) +
                           24'(`PBS_T(`PBS_SEARCH_US));
          end
        end
      end
      TASK_NOISE, TASK_SEARCH: begin
        if (wr_ctrl && (wval[`PBS_C_NREQ] || wval[`PBS_C_SREQ])) begin
          refused_nxt = 1'b1;
        end
        if (tick_r) task_el_nxt = task_el_r + 24'h1;
        if (near_dis) begin
          task_nxt = TASK_IDLE;
          rx_shut_nxt = 1'b1;
          cut_nxt = 1'b1;
        end else if (task_el_r >= task_end_r) begin
          // chained search extends the end point
          if (task_r == TASK_NOISE && chain_ok) begin
            task_nxt = TASK_SEARCH;
            task_end_nxt = 24'(warm_total) + 24'(cfg_r.ast) +
                           24'(`PBS_T(`PBS_BOTH_US));
          end else begin
            task_nxt = TASK_IDLE;
            rx_shut_nxt = 1'b1;
          end
        end
      end
      default: task_nxt = TASK_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h0;
      w_hold_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'h0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r <= w_hold_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= '0;
      rpt_r <= '0;
      task_r <= TASK_IDLE;
      div_r <= 14'h0;
      tick_r <= 1'b0;
      recalc_r <= 1'b0;
      sched_on_r <= 1'b0;
      warm_done_r <= 1'b0;
      tasks_dis_r <= 1'b0;
      rx_warm_r <= 1'b0;
      rx_shut_r <= 1'b0;
      refused_r <= 1'b0;
      cut_r <= 1'b0;
      elapsed_r <= 24'h0;
      warm_pt_r <= 24'h0;
      dis_pt_r <= 24'h0;
      task_el_r <= 24'h0;
      task_end_r <= 24'h0;
    end else begin
      cfg_r <= cfg_nxt;
      rpt_r <= rpt_nxt;
      task_r <= task_nxt;
      div_r <= div_nxt;
      tick_r <= tick_nxt;
      recalc_r <= recalc_nxt;
      sched_on_r <= sched_on_nxt;
      warm_done_r <= warm_done_nxt;
      tasks_dis_r <= tasks_dis_nxt;
      rx_warm_r <= rx_warm_nxt;
      rx_shut_r <= rx_shut_nxt;
      refused_r <= refused_nxt;
      cut_r <= cut_nxt;
      elapsed_r <= elapsed_nxt;
      warm_pt_r <= warm_pt_nxt;
      dis_pt_r <= dis_pt_nxt;
      task_el_r <= task_el_nxt;
      task_end_r <= task_end_nxt;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign rx_warmup_start = rx_warm_r;
  assign rx_shutdown_start = rx_shut_r;
  assign tasks_disabled = tasks_dis_r;

  a_sync_warm_pt: assert property (@(posedge aclk) disable iff (!aresetn)
    recalc_r && cfg_r.sync && rpt_r.time_to_next_frame > 8'h2 |=> 32'(warm_pt_r) ==
    32'($past(rpt_r.time_to_next_frame)) * 640 + 32'($past(skip)) * 14995 +
    32'($past(cfg_r.rx_off)) - 1340) else $error("sync warm point wrong");
  a_sync_dis_pt: assert property (@(posedge aclk) disable iff (!aresetn)
    recalc_r && cfg_r.sync && rpt_r.time_to_next_frame > 8'h3 |=> 32'(dis_pt_r) ==
    32'($past(rpt_r.time_to_next_frame)) * 640 + 32'($past(skip)) * 14995 - 1980)
    else $error("sync disable point wrong");
  a_async_warm_pt: assert property (@(posedge aclk) disable iff (!aresetn)
    recalc_r && !cfg_r.sync && rpt_r.time_to_next_frame > 8'h1 |=> 32'(warm_pt_r) ==
    (32'($past(rpt_r.time_to_next_frame)) - 2) * 640 + 32'($past(cfg_r.rx_off)))
    else $error("async warm point wrong");
  a_async_dis_pt: assert property (@(posedge aclk) disable iff (!aresetn)
    recalc_r && !cfg_r.sync && rpt_r.time_to_next_frame > 8'h2 |=> 32'(dis_pt_r) ==
    (32'($past(rpt_r.time_to_next_frame)) - 3) * 640) else $error("async disable point wrong");
  a_warm_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_warm_r |-> $rose(warm_done_r) ##1 !rx_warm_r)
    else $error("warm-up start not a single edge");
  a_shut_first: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(tasks_dis_r) |-> task_r == TASK_IDLE)
    else $error("task still running at disable point");
  a_noise_len: assert property (@(posedge aclk) disable iff (!aresetn)
    task_r == TASK_IDLE ##1 task_r == TASK_NOISE |-> task_el_r == 24'h0 &&
    32'(task_end_r) == 32'(warm_total) + 656) else $error("noise length wrong");
  a_search_len: assert property (@(posedge aclk) disable iff (!aresetn)
    task_r == TASK_IDLE ##1 task_r == TASK_SEARCH |-> 32'(task_end_r) ==
    32'(warm_total) + 32'(cfg_r.ast) + 376) else $error("search length wrong");
  a_chain_len: assert property (@(posedge aclk) disable iff (!aresetn)
    task_r == TASK_NOISE ##1 task_r == TASK_SEARCH |-> 32'(task_end_r) ==
    32'(warm_total) + 32'(cfg_r.ast) + 1016) else $error("chain length wrong");
  a_chain_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    task_r == TASK_NOISE ##1 task_r == TASK_SEARCH |->
    $past(!cfg_r.sync && !cfg_r.auto_search_disable)) else $error("chain not allowed");

endmodule : pbs_scheduler

// [rtl/pbs_params.svh]
`ifndef PBS_PARAMS_SVH
`define PBS_PARAMS_SVH

// timing base
`define PBS_CLK_NS 10
`define PBS_TICK_US 125
`define PBS_TICK_CYC ((`PBS_TICK_US * 1000) / `PBS_CLK_NS)
`define PBS_T(us) ((us) / `PBS_TICK_US)

// schedule and task times, microseconds; async warm-up and disable offsets in frames
`define PBS_FRAME_US 80000
`define PBS_SKIP_US 1874375
`define PBS_SWARM_US 167500
`define PBS_SDIS_US 247500
`define PBS_AWARM_N 2
`define PBS_ADIS_N 3
`define PBS_NOISE_US 82000
`define PBS_SEARCH_US 47000
`define PBS_BOTH_US 127000

// register byte offsets
`define PBS_A_CTRL 8'h00
`define PBS_A_REPORT 8'h04
`define PBS_A_RXOFF 8'h08
`define PBS_A_STEPS 8'h0C
`define PBS_A_WCFG 8'h10
`define PBS_A_AST 8'h14
`define PBS_A_STAT 8'h18
`define PBS_A_WPT 8'h1C
`define PBS_A_DPT 8'h20

// control bit positions
`define PBS_C_SYNC 0
`define PBS_C_DAS 1
`define PBS_C_NREQ 2
`define PBS_C_SREQ 3
`define PBS_C_CLR 4

// bus answers
`define PBS_OKAY 2'h0
`define PBS_SLVERR 2'h2

`endif

// [rtl/pbs_pkg.sv]
package pbs_pkg;

  typedef struct packed {
    logic [7:0] time_to_next_frame;
    logic [6:0] next_needed_frame;
    logic [6:0] cf;
  } pbs_report_s;

  typedef struct packed {
    logic sync;
    logic auto_search_disable;
    logic [3:0] step_en;
    logic [15:0] sync_set;
    logic [31:0] steps;
    logic [15:0] rx_off;
    logic [15:0] ast;
  } pbs_cfg_s;

  typedef enum logic [1:0] {
    TASK_IDLE,
    TASK_NOISE,
    TASK_SEARCH
  } pbs_task_e;

endpackage : pbs_pkg

// [verif/pbs_host_model.sv]
`timescale 1ns/1ps
`include "pbs_params.svh"

module pbs_host_model (
  // clock
  input wire logic aclk,
  // axi4-lite write
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // axi4-lite read
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // handshakes judged at the falling edge, acted on at the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ta, tw, tb, done;
    done = 1'b0;
    r = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      if (tb) r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ta, tr, done;
    done = 1'b0;
    r = 2'h3;
    d = 32'h0000_0000;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid & rready;
      if (tr) d = rdata;
      if (tr) r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd

  // frame numbers packed so the gap can be derived
  task automatic report(input logic [7:0] time_to_next_frame, input logic [6:0] cf,
                        input logic [6:0] next_needed_frame);
    logic [1:0] r;
    wr(`PBS_A_REPORT, {8'h00, time_to_next_frame, 1'b0, next_needed_frame, 1'b0, cf}, r);
  endtask : report
endmodule : pbs_host_model

// [verif/test_pager_battery_save_scheduler.sv]
`timescale 1ns/1ps
`include "pbs_params.svh"

module test_pager_battery_save_scheduler;
  import pbs_pkg::*;
  localparam int T = 4;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, psf, warm, shut, dis;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int err_count, tests_run, t0, ts, td, tw;
  // one driver only: the counting process below
  int cyc = 0;

  pbs_scheduler #(.TICK_CYC(T)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .paging_signal_found(psf), .rx_warmup_start(warm),
    .rx_shutdown_start(shut), .tasks_disabled(dis)
  );

  pbs_host_model host_u (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) cyc <= cyc + 1;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int lo, input int hi,
                         input int g);
    tests_run++;
    if (g < lo || g > hi) begin
      err_count++;
      $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  // bounded wait, polled at the falling edge where outputs are settled
  task automatic wait_sig(input int sel, input int lim, output int t);
    int n;
    logic s;
    n = 0;
    s = 1'b0;
    while (n < lim && !s) begin
      @(negedge aclk);
      s = (sel == 0) ? warm === 1'b1 : (sel == 1) ? shut === 1'b1 :
          dis === 1'b1;
      n++;
    end
    t = cyc;
    chk("wait ends", 1, s);
  endtask : wait_sig

  task automatic t_bus;
    host_u.rd(8'h24, d, r);
    chk("unmapped rresp", `PBS_SLVERR, r);
    chk("unmapped rdata", 32'h0000_0000, d);
    host_u.rd(8'h02, d, r);
    chk("unaligned rresp", `PBS_SLVERR, r);
    host_u.wr(`PBS_A_STAT, 32'hffff_ffff, r);
    chk("read-only bresp", `PBS_SLVERR, r);
    host_u.wr(`PBS_A_RXOFF, 32'h0000_000a, r);
    chk("rxoff bresp", `PBS_OKAY, r);
    host_u.rd(`PBS_A_RXOFF, d, r);
    chk("rxoff", 32'h0000_000a, d);
  endtask : t_bus

  task automatic t_points(input logic sync, input logic [7:0] time_to_next_frame,
                          input logic [6:0] cf, input logic [6:0] next_needed_frame,
                          input int ew, input int ed, input int es);
    host_u.wr(`PBS_A_CTRL, {31'h0, sync}, r);
    host_u.report(time_to_next_frame, cf, next_needed_frame);
    host_u.rd(`PBS_A_WPT, d, r);
    chk("warm point", ew, {8'h00, d[23:0]});
    host_u.rd(`PBS_A_DPT, d, r);
    chk("disable point", ed, {8'h00, d[23:0]});
    host_u.rd(`PBS_A_STAT, d, r);
    chk("skipped", es, {25'h0, d[14:8]});
  endtask : t_points

  // sync run: a task too long for the window is cut before disable
  task automatic t_cut;
    host_u.wr(`PBS_A_CTRL, 32'h0000_0001, r);
    host_u.report(8'd4, 7'd5, 7'd6);
    t0 = cyc;
    host_u.wr(`PBS_A_CTRL, 32'h0000_0005, r);
    wait_sig(1, 3000, ts);
    chk_rng("cut time", 578 * T, 579 * T + 4, ts - t0);
    chk("disabled at cut", 0, dis);
    wait_sig(2, 100, td);
    chk_rng("disable time", 579 * T, 580 * T + 4, td - t0);
    host_u.wr(`PBS_A_CTRL, 32'h0000_0005, r);
    host_u.rd(`PBS_A_STAT, d, r);
    chk("cut and refused", 3'b111, {d[5:4], d[2]});
    wait_sig(0, 3000, tw);
    chk_rng("warm time", 1229 * T, 1230 * T + 4, tw - t0);
    @(negedge aclk);
    chk("warm pulse", 0, warm);
  endtask : t_cut

  task automatic t_tasks;
    logic [31:0] ctl [4];
    logic ps [4];
    int ee [4];
    ctl = '{32'h0000_0004, 32'h0000_0006, 32'h0000_0008, 32'h0000_000c};
    ps = '{1'b0, 1'b1, 1'b1, 1'b1};
    ee = '{32 + 656, 32 + 656, 32 + 30 + 376, 32 + 30 + 1016};
    // clear sticky flags left by the cut run, so the busy refusal is real
    host_u.wr(`PBS_A_CTRL, 32'h0000_0010, r);
    host_u.rd(`PBS_A_STAT, d, r);
    chk("flags cleared", 2'b00, d[5:4]);
    host_u.report(8'd200, 7'd0, 7'd1);
    host_u.wr(`PBS_A_WCFG, 32'h0000_1405, r);
    host_u.wr(`PBS_A_STEPS, 32'h0807_0605, r);
    host_u.wr(`PBS_A_AST, 32'h0000_001e, r);
    for (int i = 0; i < 4; i++) begin
      psf <= ps[i];
      // every task ends well before the disable point
      host_u.wr(`PBS_A_CTRL, ctl[i], r);
      t0 = cyc;
      if (i == 0) begin
        host_u.wr(`PBS_A_CTRL, 32'h0000_0008, r);
        host_u.rd(`PBS_A_STAT, d, r);
        chk("busy refused", 2'b11, d[4:3]);
      end
      wait_sig(1, 5000, ts);
      chk_rng("task end", (ee[i] - 1) * T - 3, ee[i] * T + 3, ts - t0);
    end
    host_u.wr(`PBS_A_CTRL, 32'h0000_0010, r);
    host_u.rd(`PBS_A_STAT, d, r);
    chk("refused cleared", 0, d[4]);
  endtask : t_tasks

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (40000) @(posedge aclk);
    err_count++;
    final_report();
  end

  initial begin
    err_count = 0;
    tests_run = 0;
    aresetn = 1'b0;
    psf = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("idle outputs", 3'b000, {warm, shut, dis});
    t_bus();
    t_points(1'b0, 8'd4, 7'd10, 7'd13, 4 * 640 + 10 - 1280, 4 * 640 - 1920, 2);
    t_points(1'b1, 8'd0, 7'd127, 7'd1, 14995 + 10 - 1340, 14995 - 1980, 1);
    t_cut();
    t_tasks();
    final_report();
  end
endmodule : test_pager_battery_save_scheduler
